// ===== rtl/mpsi_defs.vh
// constants for the motor power safety interlock
`ifndef MPSI_DEFS_VH
`define MPSI_DEFS_VH
// startup self-check pulse length of the force-stop request
`define MPSI_SELFCHK_NS 1000
`define MPSI_CLK_NS 100
`define MPSI_SELFCHK_CYC (`MPSI_SELFCHK_NS / `MPSI_CLK_NS)
// settle time after the forced inputs are released, before run
`define MPSI_SETTLE_CYC 3
// self-check sequencer states
`define MPSI_ST_PULSE 2'h0
`define MPSI_ST_CHECK 2'h1
`define MPSI_ST_RUN 2'h2
`define MPSI_ST_FAIL 2'h3
// manual-mode limit reset values
`define MPSI_MAN_TORQUE_RST 8'h19
`define MPSI_MAN_SPEED_RST 16'h00fa
`endif

// ===== rtl/mpsi_interlock.v
// motor power safety interlock for the remote front panel
`timescale 1ns/10ps
`include "mpsi_defs.vh"
module mpsi_interlock #(
  parameter COPIES = 2,
  parameter SELFCHK_CYC = `MPSI_SELFCHK_CYC,
  parameter TW = 8,
  parameter SW = 16
) (
  input wire clk,
  input wire reset_n,
  input wire auto_mode_a,
  input wire auto_mode_b,
  input wire emergency_stop_a_n,
  input wire emergency_stop_b_n,
  input wire external_stop_source_n,
  input wire lamp_fault,
  input wire power_enable_button,
  input wire sw_force_stop,
  input wire [TW-1:0] auto_torque_limit,
  input wire [SW-1:0] auto_speed_limit,
  input wire [TW-1:0] manual_torque_limit,
  input wire [SW-1:0] manual_speed_limit,
  input wire non_jog_motion_request,
  output wire force_stop_request_n,
  output wire [COPIES-1:0] force_stop_request_copy_n,
  output reg motor_power_enable,
  output reg auto_mode,
  output reg stop_active,
  output reg external_stop_seen,
  output reg lamp_failed,
  output reg non_jog_allowed,
  output reg [TW-1:0] torque_limit,
  output reg [SW-1:0] speed_limit,
  output reg self_check_done,
  output reg self_check_fail
);

  // two-flop synchronisers for all seven panel inputs, stage one read only
  // by stage two; reset values are the unsafe levels
  // bit map of the synchronised vector:
  //   0 primary selector, 1 primary stop loop, 2 redundant stop loop,
  //   3 external stop source, 4 lamp fault, 5 enable push-button
  // the redundant selector has its own pair of flops below, so each
  // selector is seen on its own and a disagreement is never hidden
  // by an early and before the synchroniser
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  wire [5:0] raw_in;
  assign raw_in = {power_enable_button, lamp_fault, external_stop_source_n,
                   emergency_stop_b_n, emergency_stop_a_n,
                   auto_mode_a};
  reg auto_b_s1_q;
  reg auto_b_s2_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 6'h10;
      sync2_q <= 6'h10;
      auto_b_s1_q <= 1'b0;
      auto_b_s2_q <= 1'b0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      auto_b_s1_q <= auto_mode_b;
      auto_b_s2_q <= auto_b_s1_q;
    end
  end

  // decoded panel levels; open inputs read low, so every default but lamp_fault is safe; an open lamp line reads as no fault
  wire auto_a = sync2_q[0];
  wire auto_b = auto_b_s2_q;
  wire stop_a = ~sync2_q[1];
  wire stop_b = ~sync2_q[2];
  wire ext_stop = ~sync2_q[3];
  wire lamp_bad = sync2_q[4];
  wire button = sync2_q[5];
  // any disagreement between a pair falls to the unsafe meaning
  wire auto_now = auto_a & auto_b;
  wire stop_now = stop_a | stop_b;

  // startup self-check sequencer and its cycle counter
  // the pulse state holds the force-stop request low, then the panel's
  // answer is judged on the last pulse cycle; a failed check parks the
  // sequencer for good, so only a reset can bring power back
  // limitation: the check looks once, it does not watch the lines fall
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  always @* begin
    st_d = st_q;
    cnt_d = cnt_q + 16'h0001;
    case (st_q)
      `MPSI_ST_PULSE: begin
        if (cnt_q >= SELFCHK_CYC[15:0] - 16'h0001) begin
          // panel must now show every stop line forced low
          st_d = (stop_a & stop_b & ext_stop) ? `MPSI_ST_CHECK
                                              : `MPSI_ST_FAIL;
          cnt_d = 16'h0000;
        end
      end
      `MPSI_ST_CHECK: begin
        // released stop lines need a few cycles through the synchroniser
        if (cnt_q >= `MPSI_SETTLE_CYC) begin
          st_d = `MPSI_ST_RUN;
        end
      end
      `MPSI_ST_RUN: cnt_d = cnt_q;
      `MPSI_ST_FAIL: cnt_d = cnt_q;
      default: st_d = `MPSI_ST_FAIL;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= `MPSI_ST_PULSE;
      cnt_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // force-stop request: low during the startup pulse or on software demand
  reg force_n_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      force_n_q <= 1'b0;
    end else begin
      force_n_q <= ~((st_d == `MPSI_ST_PULSE) | sw_force_stop);
    end
  end
  assign force_stop_request_n = force_n_q;

  // redundant copies all come from the same flop, so they never differ
  genvar gi;
  generate
    for (gi = 0; gi < COPIES; gi = gi + 1) begin : g_copy
      assign force_stop_request_copy_n[gi] = force_n_q;
    end
  endgenerate

  // enable sequencing: a rising edge arms, any blocker drops at once
  // the edge is taken from the synchronised level, so a press shorter
  // than a clock period may be missed; panel buttons are far slower
  // a press that lands while blocked is lost and must be repeated
  reg button_q;
  reg auto_q;
  wire run_ok = (st_q == `MPSI_ST_RUN);
  wire to_manual = auto_q & ~auto_now;
  wire blocked = stop_now | lamp_bad | to_manual | ~run_ok;
  wire rise = button & ~button_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      button_q <= 1'b1;
      auto_q <= 1'b0;
      motor_power_enable <= 1'b0;
    end else begin
      // button_q resets high, but sync2_q resets the button bit low, so a button held through reset gives one edge, lost while the self-check blocks
      button_q <= button;
      auto_q <= auto_now;
      if (blocked) begin
        motor_power_enable <= 1'b0;
      end else if (rise) begin
        motor_power_enable <= 1'b1;
      end
    end
  end

  // status and mode-selected auto or manual limits for the servo and motion logic
  // limits are registered so the servo side never sees a mixed word
  // while the selector pair is changing
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_mode <= 1'b0;
      stop_active <= 1'b1;
      external_stop_seen <= 1'b0;
      lamp_failed <= 1'b1;
      non_jog_allowed <= 1'b0;
      torque_limit <= `MPSI_MAN_TORQUE_RST;
      speed_limit <= `MPSI_MAN_SPEED_RST;
      self_check_done <= 1'b0;
      self_check_fail <= 1'b0;
    end else begin
      auto_mode <= auto_now;
      stop_active <= stop_now;
      // ignore the forced low while the startup check drives it
      external_stop_seen <= ext_stop & run_ok;
      lamp_failed <= lamp_bad;
      non_jog_allowed <= auto_now & ~non_jog_motion_request | auto_now;
      torque_limit <= auto_now ? auto_torque_limit
                               : manual_torque_limit;
      speed_limit <= auto_now ? auto_speed_limit : manual_speed_limit;
      self_check_done <= run_ok;
      self_check_fail <= (st_q == `MPSI_ST_FAIL);
    end
  end

endmodule

// ===== bench/mpsi_panel_model.sv
// front panel model: stop loops, external stop and forced stop
`timescale 1ns/10ps
module mpsi_panel_model (
  input wire force_n,
  input wire stop_press,
  input wire ext_press,
  output wire stop_a_n,
  output wire stop_b_n,
  output wire ext_n
);
  // a forced stop drags both loops and the external line low
  assign stop_a_n = force_n & ~stop_press & ~ext_press;
  assign stop_b_n = force_n & ~stop_press & ~ext_press;
  assign ext_n = force_n & ~ext_press;
endmodule

// ===== bench/mpsi_interlock_asserts.sv
// concurrent checks on the interlock ports
`timescale 1ns/10ps
module mpsi_interlock_asserts #(parameter COPIES = 2) (
  input wire clk,
  input wire reset_n,
  input wire auto_mode_a,
  input wire auto_mode_b,
  input wire emergency_stop_a_n,
  input wire emergency_stop_b_n,
  input wire lamp_fault,
  input wire power_enable_button,
  input wire sw_force_stop,
  input wire force_stop_request_n,
  input wire [COPIES-1:0] force_stop_request_copy_n,
  input wire motor_power_enable,
  input wire auto_mode,
  input wire lamp_failed,
  input wire non_jog_allowed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // copies never differ from the primary request
  a_copy_equal: assert property (force_stop_request_copy_n ==
    {COPIES{force_stop_request_n}}) else $error("copy differs");
  a_stop_a_blocks: assert property (!emergency_stop_a_n [*4]
    |-> !motor_power_enable) else $error("power on in stop");
  a_stop_b_blocks: assert property (!emergency_stop_b_n [*4]
    |-> !motor_power_enable) else $error("power on in stop b");
  a_lamp_blocks: assert property (lamp_fault [*4]
    |-> !motor_power_enable && lamp_failed) else $error("lamp fault");
  a_sw_forces: assert property (sw_force_stop [*2]
    |-> !force_stop_request_n) else $error("force not driven");
  // power comes up three edges after a low-to-high button step
  a_enable_edge: assert property ($rose(motor_power_enable)
    |-> $past(power_enable_button, 3) && !$past(power_enable_button, 4))
    else $error("enable no press");
  a_manual_drop: assert property ($fell(auto_mode)
    |-> !motor_power_enable) else $error("manual kept power");
  a_pair_unsafe: assert property ((auto_mode_a != auto_mode_b) [*4]
    |-> !auto_mode && !non_jog_allowed) else $error("pair not unsafe");
endmodule

// ===== bench/testbench.sv
// self-checking bench for the interlock
`timescale 1ns/10ps
module testbench;
  reg clk = 0, rst_n = 0, am_a = 1, am_b = 1, stp = 0, ext = 0;
  reg lamp = 0, btn = 0, swf = 0;
  wire f_n, sa_n, sb_n, ex_n, en, am, sa, es, lf, nj, done, fl;
  wire [1:0] cp;
  wire [7:0] tq;
  wire [15:0] sp;
  int fail_count = 0, check_count = 0, i;
  always #50 clk = ~clk;
  mpsi_panel_model panel (.force_n(f_n), .stop_press(stp),
    .ext_press(ext), .stop_a_n(sa_n), .stop_b_n(sb_n), .ext_n(ex_n));
  mpsi_interlock dut (.clk(clk), .reset_n(rst_n), .auto_mode_a(am_a),
    .auto_mode_b(am_b), .emergency_stop_a_n(sa_n),
    .emergency_stop_b_n(sb_n), .external_stop_source_n(ex_n),
    .lamp_fault(lamp), .power_enable_button(btn), .sw_force_stop(swf),
    .auto_torque_limit(8'h64), .auto_speed_limit(16'h0400),
    .manual_torque_limit(8'h0c), .manual_speed_limit(16'h0020),
    .non_jog_motion_request(1'h0), .force_stop_request_n(f_n),
    .force_stop_request_copy_n(cp), .motor_power_enable(en),
    .auto_mode(am), .stop_active(sa), .external_stop_seen(es),
    .lamp_failed(lf), .non_jog_allowed(nj), .torque_limit(tq),
    .speed_limit(sp), .self_check_done(done), .self_check_fail(fl));
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %0t mismatch %h exp %h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // startup pulse must drag the loops low, then release
  task t_startup;
    step(2);
    chk(f_n, 0);
    chk(sa, 1);
    for (i = 0; i < 60 && done !== 1; i++) step(1);
    chk({done, fl, f_n}, 3'h5);
  endtask
  // held button must not re-enable after a stop clears
  task t_stop;
    btn <= 1; step(5); chk(en, 1);
    stp <= 1; step(5); chk({en, sa}, 2'h1);
    stp <= 0; step(5); chk(en, 0);
    btn <= 0; lamp <= 1; step(5); btn <= 1; step(5);
    chk({en, lf}, 2'h1);
    btn <= 0; lamp <= 0; step(5);
  endtask
  // one selector dropping forces manual limits and removes power
  task t_mode;
    btn <= 1; step(5); chk({en, am, nj, tq}, 11'h764);
    chk(sp, 16'h0400);
    btn <= 0; am_b <= 0; step(5);
    chk({en, am, nj, tq}, 11'h00c);
    chk(sp, 16'h0020);
    am_b <= 1; step(5); chk({en, am}, 2'h1);
  endtask
  // external stop reported; software force reaches all copies
  task t_force;
    ext <= 1; step(5); chk(es, 1);
    ext <= 0; swf <= 1; step(5); chk({f_n, cp, sa}, 4'h1);
    swf <= 0; step(5); chk({f_n, cp}, 3'h7);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    t_startup;
    t_stop;
    t_mode;
    t_force;
    give_verdict;
  end
  // watchdog well beyond the fewer than a hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    give_verdict;
  end
endmodule
bind mpsi_interlock mpsi_interlock_asserts #(.COPIES(COPIES)) chk_i (
  .clk(clk), .reset_n(reset_n), .auto_mode_a(auto_mode_a),
  .auto_mode_b(auto_mode_b), .emergency_stop_a_n(emergency_stop_a_n),
  .emergency_stop_b_n(emergency_stop_b_n), .lamp_fault(lamp_fault),
  .power_enable_button(power_enable_button),
  .sw_force_stop(sw_force_stop),
  .force_stop_request_n(force_stop_request_n),
  .force_stop_request_copy_n(force_stop_request_copy_n),
  .motor_power_enable(motor_power_enable), .auto_mode(auto_mode),
  .lamp_failed(lamp_failed), .non_jog_allowed(non_jog_allowed));
